// ===== ctrl_word_crc.sv
module ctrl_word_crc
    import route_codec_pkg::*;
(
    input  wire logic [COVER_W-1:0] data,
    output logic      [23:0]        crc
);
    logic [23:0] acc;
    logic        fb;

    // Bit-serial form unrolled by the loop, MSB first
    always_comb begin
        acc = CRC_INIT;
        fb  = 1'b0;
        for (int i = COVER_W - 1; i >= 0; i--) begin
            fb  = acc[23] ^ data[i];
            acc = {acc[22:0], 1'b0};
            if (fb) begin
                acc = acc ^ CRC_POLY;
            end
        end
        crc = acc;
    end
endmodule : ctrl_word_crc

// ===== host_link_model.sv
module host_link_model
    import route_codec_pkg::*;
(
    input  wire logic              clk,
    output logic                   rx_valid,
    output logic                   rx_is_ctrl,
    output logic [WORD_W-1:0]      rx_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Word builders
    // ------------------------------------------------------------------
    initial begin
        rx_valid = 1'b0;
        rx_is_ctrl = 1'b0;
        rx_word = '0;
    end

    function automatic logic [23:0] crc24(input logic [COVER_W-1:0] d);
        logic [23:0] c;
        c = CRC_INIT;
        for (int i = COVER_W - 1; i >= 0; i--) begin
            c = {c[22:0], 1'b0} ^ ((c[23] ^ d[i]) ? CRC_POLY : 24'h0);
        end
        return c;
    endfunction : crc24

    function automatic logic [WORD_W-1:0] make_ctrl(input logic [1:0] typ, input logic [14:0] ctx,
                                                    input logic bank, input logic [1:0] err);
        logic [WORD_W-1:0] w;
        logic [8:0]        op;
        op = (typ == RT_TYPE1) ? OP_TYPE1 : (typ == RT_TYPE2) ? OP_TYPE2 : OP_TYPE3;
        w = '0;
        w[56:42] = ctx;
        w[38:33] = op[5:0];
        w[31:30] = err;
        w[27] = bank;
        w[26:24] = op[8:6];
        w[23:0] = crc24(w[66:24]);
        return w;
    endfunction : make_ctrl

    task automatic send(input logic [1:0] typ, input logic [14:0] ctx, input logic bank,
                        input logic [PAYLOAD_W-1:0] pl, input logic bad);
        int n;
        n = (typ == RT_TYPE1) ? 5 : 2;
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_is_ctrl <= 1'b1;
        rx_word <= make_ctrl(typ, ctx, bank, ERR_OK) ^ {66'h0, bad};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_is_ctrl <= 1'b0;
            rx_word <= {3'h0, pl[319-64*i -: 64]};
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        // Idle bus never repeats the last word, so a stale sample shows up
        rx_word <= ~rx_word;
    endtask : send
endmodule : host_link_model

// ===== route_codec_monitor.sv
module route_codec_monitor
    import route_codec_pkg::*;
(
    input wire logic                CLK_SYS,
    input wire logic                RST_N,
    input wire logic                REQ_VALID,
    input wire logic [1:0]          REQ_TYPE,
    input wire logic [14:0]         REQ_CONTEXT,
    input wire logic                REQ_BANK,
    input wire logic [1:0]          REQ_ERROR,
    input wire logic                TX_VALID,
    input wire logic                TX_IS_CTRL,
    input wire logic [WORD_W-1:0]   TX_WORD,
    input wire logic [1:0]          TX_DEVICE_ID
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Response checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic       resp_due;
    logic       tx_ctrl;
    logic [8:0] exp_op;
    assign resp_due = REQ_VALID && (REQ_TYPE == RT_TYPE1 || REQ_TYPE == RT_TYPE2);
    assign tx_ctrl  = TX_VALID && TX_IS_CTRL;
    // Type is held until the next decode, which cannot land before the reply
    assign exp_op   = (REQ_TYPE == RT_TYPE1) ? OP_TYPE1 : OP_TYPE2;

    a_resp_timing: assert property (resp_due |=> !TX_IS_CTRL ##1 tx_ctrl)
        else $error("response control word not two cycles after decode");
    a_data_zero: assert property (tx_ctrl |=>
        (TX_VALID && !TX_IS_CTRL && TX_WORD == '0) [*2] ##1 (!TX_VALID || TX_IS_CTRL))
        else $error("response data words wrong");
    a_bank_echo: assert property (resp_due |->
        ##2 TX_WORD[BANK_BIT] == $past(REQ_BANK, 2)) else $error("bank select not echoed");
    a_ctx_echo: assert property (resp_due |->
        ##2 TX_WORD[CTX_HI:CTX_LO] == $past(REQ_CONTEXT, 2))
        else $error("context address not echoed");
    a_operation_code_echo: assert property (tx_ctrl |->
        {TX_WORD[OPHI_HI:OPHI_LO], TX_WORD[OPLO_HI:OPLO_LO]} == exp_op) else $error("bad operation_code echo");
    a_err_status: assert property (tx_ctrl |->
        TX_WORD[ERR_HI:ERR_LO] == REQ_ERROR && TX_WORD[29:28] == 2'h0) else $error("bad error status");
    a_frame_clear: assert property (tx_ctrl |->
        TX_WORD[66:57] == '0 && !TX_WORD[RSVD_BIT] && TX_WORD[40:39] == 2'h0 && !TX_WORD[32])
        else $error("framing or reserved bits set");
    a_target_device_id_hold: assert property (TX_VALID && !TX_IS_CTRL |-> $stable(TX_DEVICE_ID))
        else $error("device id changed within response");
    a_type3_quiet: assert property (REQ_VALID && REQ_TYPE == RT_TYPE3 |-> ##2 !TX_VALID)
        else $error("type 3 request answered");
endmodule : route_codec_monitor

// ===== route_codec_pkg.sv
package route_codec_pkg;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int WORD_W       = 67;
    localparam int DATA_W       = 64;
    localparam int PAYLOAD_W    = 320;
    localparam int CTX_HI       = 56;
    localparam int CTX_LO       = 42;
    localparam int RSVD_BIT     = 41;
    localparam int OPLO_HI      = 38;
    localparam int OPLO_LO      = 33;
    localparam int ERR_HI       = 31;
    localparam int ERR_LO       = 30;
    localparam int BANK_BIT     = 27;
    localparam int OPHI_HI      = 26;
    localparam int OPHI_LO      = 24;
    localparam int CRC_HI       = 23;
    localparam int CRC_LO       = 0;
    localparam int CRC_COVER_HI = 66;
    localparam int CRC_COVER_LO = 24;
    localparam int COVER_W      = CRC_COVER_HI - CRC_COVER_LO + 1;

    // ------------------------------------------------------------------
    // Operation codes and request types
    // ------------------------------------------------------------------
    localparam logic [8:0] OP_TYPE1    = 9'h00c;
    localparam logic [8:0] OP_TYPE2    = 9'h00d;
    localparam logic [8:0] OP_TYPE3    = 9'h00e;
    localparam logic [1:0] RT_NONE     = 2'h0;
    localparam logic [1:0] RT_TYPE1    = 2'h1;
    localparam logic [1:0] RT_TYPE2    = 2'h2;
    localparam logic [1:0] RT_TYPE3    = 2'h3;
    localparam logic [2:0] WORDS_LONG  = 3'h5;
    localparam logic [2:0] WORDS_SHORT = 3'h2;
    localparam logic [1:0] RSP_WORDS   = 2'h2;
    localparam logic [1:0] ERR_OK      = 2'h0;
    localparam logic [1:0] ERR_CRC     = 2'h1;
    localparam logic [1:0] ERR_FMT     = 2'h2;

    // ------------------------------------------------------------------
    // Check sequence
    // ------------------------------------------------------------------
    localparam logic [23:0] CRC_POLY = 24'h800063;
    localparam logic [23:0] CRC_INIT = 24'hffffff;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
    localparam logic [11:0] ADDR_INT_ENABLE = 12'h00c;
    localparam logic [11:0] ADDR_INT_CLEAR  = 12'h010;
    localparam logic [11:0] ADDR_LAST_REQ   = 12'h014;
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_TARGET_DEVICE_ID_LO   = 1;
    localparam logic        CTRL_EN_RESET   = 1'b1;
    localparam logic [1:0]  TARGET_DEVICE_ID_RESET     = 2'h0;
    localparam int          EV_DECODED      = 0;
    localparam int          EV_CRC          = 1;
    localparam int          EV_FMT          = 2;
    localparam int          EV_OPERATION_CODE       = 3;
    localparam int          EV_RESP         = 4;
    localparam int          EV_W            = 5;

    typedef enum logic [0:0] {RX_IDLE, RX_DATA} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_CTRL, TX_DATA} tx_state_t;

endpackage : route_codec_pkg

// ===== route_instruction_word_codec.sv
// Notes on behaviour
// - A type-1 request carries low code 001100 at 38:33 and high code 000 at 26:24.
// - A type-2 request carries low code 001101 at 38:33 and high code 000 at 26:24.
// - A type-3 request carries low code 001110 at 38:33 and high code 000 at 26:24.
// - Bits 66:57, 40:39 and 32 are framing, 56:42 hold the context address, 41 is reserved.
// - Every control word holds a 24-bit check sequence in 23:0 below the high code bits.
// - Payload byte 0 sits at 63:56 of a data word and byte 7 at 7:0.
// - The type-1 response echoes its code, puts error status at 31:30, zeros 29:28.
// - The type-2 response echoes its code, puts error status at 31:30, zeros 29:28.
// - Each response returns at bit 27 the bank select of its request.
// - Each response names its target device by a two-bit device identifier.
module route_instruction_word_codec
    import route_codec_pkg::*;
(
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST_N,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic                 RX_VALID,
    input  wire logic                 RX_IS_CTRL,
    input  wire logic [WORD_W-1:0]    RX_WORD,
    output logic                      REQ_VALID,
    output logic      [1:0]           REQ_TYPE,
    output logic      [14:0]          REQ_CONTEXT,
    output logic                      REQ_BANK,
    output logic      [1:0]           REQ_ERROR,
    output logic      [PAYLOAD_W-1:0] REQ_PAYLOAD,
    output logic                      TX_VALID,
    output logic                      TX_IS_CTRL,
    output logic      [WORD_W-1:0]    TX_WORD,
    output logic      [1:0]           TX_DEVICE_ID,
    output logic                      IRQ
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        rx_state_t           rx_st;
        logic [1:0]          cur_type;
        logic [14:0]         cur_ctx;
        logic                cur_bank;
        logic                cur_crc_bad;
        logic                cur_fmt_bad;
        logic [2:0]          expect_words;
        logic [2:0]          word_idx;
        logic [PAYLOAD_W-1:0] cur_payload;
        logic                req_valid;
        logic [1:0]          req_type;
        logic [14:0]         req_ctx;
        logic                req_bank;
        logic [1:0]          req_err;
        logic [PAYLOAD_W-1:0] req_payload;
        tx_state_t           tx_st;
        logic [1:0]          tx_cnt;
        logic                tx_valid;
        logic                tx_ctrl;
        logic [WORD_W-1:0]   tx_word;
        logic [1:0]          tx_target_device_id;
        logic                enable;
        logic [1:0]          dev_id;
        logic [EV_W-1:0]     int_status;
        logic [EV_W-1:0]     int_enable;
        logic [15:0]         decode_count;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                irq;
    } state_t;

    state_t              s;
    state_t              next_s;
    logic [8:0]          rx_operation_code;
    logic [23:0]         rx_crc_calc;
    logic [23:0]         rsp_crc_calc;
    logic [WORD_W-1:0]   rsp_word;
    logic [EV_W-1:0]     events;
    logic [DATA_W-1:0]   rx_data;
    logic                access;

    assign rx_operation_code = {RX_WORD[OPHI_HI:OPHI_LO], RX_WORD[OPLO_HI:OPLO_LO]};
    assign rx_data   = RX_WORD[DATA_W-1:0];
    assign access    = PSEL & PENABLE;

    // ------------------------------------------------------------------
    // Check sequences for incoming and outgoing control words
    // ------------------------------------------------------------------
    ctrl_word_crc u_rx_crc (
        .data (RX_WORD[CRC_COVER_HI:CRC_COVER_LO]),
        .crc  (rx_crc_calc)
    );

    // Framing bits are left zero for the framing layer to fill
    always_comb begin
        rsp_word = '0;
        rsp_word[CTX_HI:CTX_LO] = s.req_ctx;
        rsp_word[ERR_HI:ERR_LO] = s.req_err;
        rsp_word[BANK_BIT]      = s.req_bank;
        if (s.req_type == RT_TYPE1) begin
            rsp_word[OPLO_HI:OPLO_LO] = OP_TYPE1[5:0];
            rsp_word[OPHI_HI:OPHI_LO] = OP_TYPE1[8:6];
        end else begin
            rsp_word[OPLO_HI:OPLO_LO] = OP_TYPE2[5:0];
            rsp_word[OPHI_HI:OPHI_LO] = OP_TYPE2[8:6];
        end
    end

    ctrl_word_crc u_tx_crc (
        .data (rsp_word[CRC_COVER_HI:CRC_COVER_LO]),
        .crc  (rsp_crc_calc)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s           = s;
        events           = '0;
        next_s.req_valid = 1'b0;
        next_s.tx_valid  = 1'b0;
        next_s.tx_ctrl   = 1'b0;
        next_s.pready    = 1'b0;
        next_s.pslverr   = 1'b0;

        // Request decoding
        if (RX_VALID && s.enable) begin
            if (RX_IS_CTRL) begin
                // A control word mid-request cuts the old one short
                if (s.rx_st == RX_DATA) begin
                    events[EV_FMT] = 1'b1;
                end
                next_s.cur_ctx     = RX_WORD[CTX_HI:CTX_LO];
                next_s.cur_bank    = RX_WORD[BANK_BIT];
                next_s.cur_crc_bad = (rx_crc_calc != RX_WORD[CRC_HI:CRC_LO]);
                next_s.cur_fmt_bad = 1'b0;
                next_s.word_idx    = 3'h0;
                next_s.cur_payload = '0;
                next_s.rx_st       = RX_DATA;
                if (rx_operation_code == OP_TYPE1) begin
                    next_s.cur_type     = RT_TYPE1;
                    next_s.expect_words = WORDS_LONG;
                end else if (rx_operation_code == OP_TYPE2) begin
                    next_s.cur_type     = RT_TYPE2;
                    next_s.expect_words = WORDS_SHORT;
                end else if (rx_operation_code == OP_TYPE3) begin
                    next_s.cur_type     = RT_TYPE3;
                    next_s.expect_words = WORDS_SHORT;
                end else begin
                    next_s.cur_type  = RT_NONE;
                    next_s.rx_st     = RX_IDLE;
                    events[EV_OPERATION_CODE] = 1'b1;
                end
            end else if (s.rx_st == RX_DATA) begin
                // Word i lands with byte 8i in the top lane
                next_s.cur_payload[PAYLOAD_W-1-DATA_W*s.word_idx -: DATA_W] = rx_data;
                if (s.cur_type != RT_TYPE1 && s.word_idx == 3'h1 && rx_data != '0) begin
                    next_s.cur_fmt_bad = 1'b1;
                end
                next_s.word_idx = s.word_idx + 3'h1;
                if (s.word_idx + 3'h1 == s.expect_words) begin
                    next_s.rx_st       = RX_IDLE;
                    next_s.req_valid   = 1'b1;
                    next_s.req_type    = s.cur_type;
                    next_s.req_ctx     = s.cur_ctx;
                    next_s.req_bank    = s.cur_bank;
                    next_s.req_payload = next_s.cur_payload;
                    if (s.cur_crc_bad) begin
                        next_s.req_err = ERR_CRC;
                    end else if (next_s.cur_fmt_bad) begin
                        next_s.req_err = ERR_FMT;
                    end else begin
                        next_s.req_err = ERR_OK;
                    end
                    next_s.decode_count = s.decode_count + 16'h1;
                    events[EV_DECODED] = 1'b1;
                    events[EV_CRC]     = s.cur_crc_bad;
                    events[EV_FMT]     = next_s.cur_fmt_bad;
                end
            end else begin
                // Stray data word outside a request
                events[EV_FMT] = 1'b1;
            end
        end

        // Response: a request spans three words or more, but a response only returns to idle
        // four cycles after its decode, so a decode three cycles later goes unanswered
        case (s.tx_st)
            TX_IDLE: begin
                if (s.req_valid && s.req_type != RT_TYPE3) begin
                    next_s.tx_st = TX_CTRL;
                end
            end
            TX_CTRL: begin
                next_s.tx_valid = 1'b1;
                next_s.tx_ctrl  = 1'b1;
                next_s.tx_word  = {rsp_word[WORD_W-1:CRC_HI+1], rsp_crc_calc};
                next_s.tx_target_device_id = s.dev_id;
                next_s.tx_cnt   = 2'h0;
                next_s.tx_st    = TX_DATA;
            end
            TX_DATA: begin
                next_s.tx_valid = 1'b1;
                next_s.tx_word  = '0;
                next_s.tx_cnt   = s.tx_cnt + 2'h1;
                if (s.tx_cnt + 2'h1 == RSP_WORDS) begin
                    next_s.tx_st   = TX_IDLE;
                    events[EV_RESP] = 1'b1;
                end
            end
            default: begin
                next_s.tx_st = TX_IDLE;
            end
        endcase

        // APB slave: one wait state, answer registered
        if (access && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0;
            if (PADDR == ADDR_CTRL) begin
                next_s.prdata = {29'h0, s.dev_id, s.enable};
            end else if (PADDR == ADDR_STATUS) begin
                next_s.prdata = {12'h0, s.tx_st != TX_IDLE, s.rx_st == RX_DATA,
                                 s.cur_type, s.decode_count};
            end else if (PADDR == ADDR_INT_STATUS) begin
                next_s.prdata = {{(32-EV_W){1'b0}}, s.int_status};
            end else if (PADDR == ADDR_INT_ENABLE) begin
                next_s.prdata = {{(32-EV_W){1'b0}}, s.int_enable};
            end else if (PADDR == ADDR_INT_CLEAR) begin
                next_s.prdata = 32'h0;
            end else if (PADDR == ADDR_LAST_REQ) begin
                next_s.prdata = {11'h0, s.req_err, s.req_bank, s.req_type,
                                 1'b0, s.req_ctx};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        if (access && s.pready && PWRITE) begin
            if (PADDR == ADDR_CTRL) begin
                next_s.enable = PWDATA[CTRL_EN_BIT];
                next_s.dev_id = PWDATA[CTRL_TARGET_DEVICE_ID_LO +: 2];
            end else if (PADDR == ADDR_INT_ENABLE) begin
                next_s.int_enable = PWDATA[EV_W-1:0];
            end else if (PADDR == ADDR_INT_CLEAR) begin
                next_s.int_status = s.int_status & ~PWDATA[EV_W-1:0];
            end
        end
        // Set wins over a clear in the same cycle
        next_s.int_status = next_s.int_status | events;
        next_s.irq        = |(next_s.int_status & next_s.int_enable);
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s        <= '0;
            s.rx_st  <= RX_IDLE;
            s.tx_st  <= TX_IDLE;
            s.enable <= CTRL_EN_RESET;
            s.dev_id <= TARGET_DEVICE_ID_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRDATA       = s.prdata;
    assign PREADY       = s.pready;
    assign PSLVERR      = s.pslverr;
    assign REQ_VALID    = s.req_valid;
    assign REQ_TYPE     = s.req_type;
    assign REQ_CONTEXT  = s.req_ctx;
    assign REQ_BANK     = s.req_bank;
    assign REQ_ERROR    = s.req_err;
    assign REQ_PAYLOAD  = s.req_payload;
    assign TX_VALID     = s.tx_valid;
    assign TX_IS_CTRL   = s.tx_ctrl;
    assign TX_WORD      = s.tx_word;
    assign TX_DEVICE_ID = s.tx_target_device_id;
    assign IRQ          = s.irq;
endmodule : route_instruction_word_codec

// ===== tb_route_instruction_word_codec.sv
module tb_route_instruction_word_codec
    import route_codec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk_sys = 1'b0;
    logic                 rst_n, psel, penable, pwrite, pready, pslverr, rx_valid, rx_is_ctrl;
    logic                 req_valid, req_bank, tx_valid, tx_is_ctrl, irq;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata;
    logic [WORD_W-1:0]    rx_word, tx_word;
    logic [1:0]           req_type, req_error, tx_device_id;
    logic [14:0]          req_context;
    logic [PAYLOAD_W-1:0] req_payload;
    int                   error_cnt = 0;
    int                   comparisons = 0;

    always #25 clk_sys = ~clk_sys;

    route_instruction_word_codec i_route_instruction_word_codec (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_VALID(rx_valid), .RX_IS_CTRL(rx_is_ctrl), .RX_WORD(rx_word), .REQ_VALID(req_valid),
        .REQ_TYPE(req_type), .REQ_CONTEXT(req_context), .REQ_BANK(req_bank),
        .REQ_ERROR(req_error), .REQ_PAYLOAD(req_payload), .TX_VALID(tx_valid),
        .TX_IS_CTRL(tx_is_ctrl), .TX_WORD(tx_word), .TX_DEVICE_ID(tx_device_id), .IRQ(irq));
    host_link_model i_host_link_model (
        .clk(clk_sys), .rx_valid(rx_valid), .rx_is_ctrl(rx_is_ctrl), .rx_word(rx_word));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [PAYLOAD_W-1:0] seen, input logic [PAYLOAD_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_req(input logic [1:0] typ, input logic [14:0] ctx, input logic bank,
                          input logic [PAYLOAD_W-1:0] pl, input logic bad,
                          input logic [1:0] err, input logic [1:0] dev);
        int n;
        n = 0;
        i_host_link_model.send(typ, ctx, bank, pl, bad);
        do begin
            @(negedge clk_sys);
            n++;
        end while (req_valid !== 1'b1 && n < 8);
        chk({req_valid, req_type, req_context, req_bank, req_error},
            {1'b1, typ, ctx, bank, err});
        chk(req_payload, (typ == RT_TYPE1) ? pl : {pl[319:192], 192'h0});
        if (typ == RT_TYPE3) begin
            repeat (4) begin
                @(negedge clk_sys);
                chk(tx_valid, 1'b0);
            end
        end else begin
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
            end while (tx_valid !== 1'b1 && n < 8);
            chk({tx_valid, tx_is_ctrl, tx_word},
                {2'b11, i_host_link_model.make_ctrl(typ, ctx, bank, err)});
            chk(tx_device_id, dev);
            repeat (2) begin
                @(negedge clk_sys);
                chk({tx_valid, tx_is_ctrl, tx_word}, {2'b10, 67'h0});
            end
        end
    endtask : do_req

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_type1_bytes();
        logic [PAYLOAD_W-1:0] pl;
        pl = '0;
        for (int b = 0; b < 40; b++) begin
            pl[319-8*b -: 8] = 8'(b + 16);
        end
        do_req(RT_TYPE1, 15'h7fff, 1'b0, pl, 1'b0, ERR_OK, 2'h0);
    endtask : t_type1_bytes

    task automatic t_regs_irq();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        chk(rd, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h5, rd, err);
        apb(1'b1, ADDR_INT_CLEAR, 32'h1f, rd, err);
        apb(1'b1, ADDR_INT_ENABLE, 32'h1, rd, err);
        apb(1'b0, 12'h020, 32'h0, rd, err);
        chk({err, rd}, {1'b1, 32'h0});
        @(negedge clk_sys);
        chk(irq, 1'b0);
        // Bank set to one on purpose: the device must echo it even so
        do_req(RT_TYPE2, 15'h0001, 1'b1, {64'h0123456789abcdef, 256'h0},
               1'b0, ERR_OK, 2'h2);
        chk(irq, 1'b1);
        apb(1'b0, ADDR_LAST_REQ, 32'h0, rd, err);
        chk(rd, 32'h00060001);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h00020002);
        apb(1'b0, ADDR_INT_STATUS, 32'h0, rd, err);
        chk(rd[EV_DECODED], 1'b1);
        apb(1'b1, ADDR_INT_CLEAR, 32'h1, rd, err);
        apb(1'b0, ADDR_INT_STATUS, 32'h0, rd, err);
        @(negedge clk_sys);
        chk({rd[EV_DECODED], irq}, 2'b00);
    endtask : t_regs_irq

    task automatic t_type3_silent();
        do_req(RT_TYPE3, 15'h2a5a, 1'b0, {64'hfedcba9876543210, 256'h0},
               1'b0, ERR_OK, 2'h2);
    endtask : t_type3_silent

    task automatic t_crc_error();
        logic [31:0] rd;
        logic        err;
        do_req(RT_TYPE1, 15'h0000, 1'b0, {PAYLOAD_W{1'b1}}, 1'b1,
               ERR_CRC, 2'h2);
        // Nonzero second word of a short request is a format error
        do_req(RT_TYPE2, 15'h1234, 1'b0, {64'h1122334455667788, 64'h1, 192'h0},
               1'b0, ERR_FMT, 2'h2);
        apb(1'b0, ADDR_INT_STATUS, 32'h0, rd, err);
        chk(rd, 32'h00000017);
    endtask : t_crc_error

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_type1_bytes();
        t_regs_irq();
        t_type3_silent();
        t_crc_error();
        final_report();
    end

    initial begin
        #200000;
        chk(1'b0, 1'b1);
        final_report();
    end
endmodule : tb_route_instruction_word_codec

bind route_instruction_word_codec route_codec_monitor i_route_codec_monitor (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_TYPE(REQ_TYPE),
    .REQ_CONTEXT(REQ_CONTEXT), .REQ_BANK(REQ_BANK), .REQ_ERROR(REQ_ERROR),
    .TX_VALID(TX_VALID), .TX_IS_CTRL(TX_IS_CTRL), .TX_WORD(TX_WORD),
    .TX_DEVICE_ID(TX_DEVICE_ID));
